// ===== dv/sss_chk_sva.sv
// Checker for the sleep sequencer top: bus timing, sleep entry and exit
// Assumes binding to sss_top; watches its ports only
`timescale 1ns/10ps
module sss_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] wake_pin,
  input wire logic [7:0] pwr_off,
  input wire logic cpu_halt
);
  logic [11:0] aw_r;
  logic [7:0] en_r;
  logic arm_r;
  logic [11:0] wa;
  logic wtk;
  // Address that goes with a data beat, even when both land together
  assign wa = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_r;
  assign wtk = s_axi_wvalid && s_axi_wready;
  // Shadow of wake enables and of a pending sleep command
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r <= 12'h000;
      en_r <= 8'h00;
      arm_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_r <= s_axi_awaddr;
      if (wtk && wa == 12'h010) en_r <= s_axi_wdata[7:0];
      if (wtk && wa == 12'h004 && s_axi_wdata[13]) arm_r <= 1'b1;
      else if (cpu_halt) arm_r <= 1'b0;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && wtk;
  endsequence
  sequence wake_edge;
    cpu_halt && pwr_off != 8'h00 && $rose(|(wake_pin & en_r));
  endsequence
  a_halt_needs_cmd: assert property ($rose(cpu_halt) |-> arm_r)
    else $error("halt began without a sleep command");
  a_off_while_halt: assert property (pwr_off != 8'h00 |-> cpu_halt)
    else $error("power switched off while running");
  a_wake_returns: assert property (wake_edge |-> ##[1:8] !cpu_halt)
    else $error("no return to working after wake");
  a_write_answer: assert property (wr_taken |=> s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than a pulse");
  a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
    else $error("bad write response code");
endmodule // sss_chk
bind sss_top sss_chk chk_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .wake_pin, .pwr_off, .cpu_halt);

// ===== dv/sss_wake_dev.sv
// Wake device model: raises wake lines on request from the bench
// Assumes requests change just after a rising edge; lines idle low
`timescale 1ns/10ps
module sss_wake_dev (
  input wire logic aclk,
  input wire logic [7:0] fire,
  output logic [7:0] wake_pin
);
  logic [2:0] hold_r = 3'h0;
  logic [7:0] pin_r = 8'h00;
  // Held a few cycles so the two synchroniser flops surely see it
  always @(posedge aclk) begin
    if (fire != 8'h00) begin
      pin_r <= fire;
      hold_r <= 3'h4;
    end else if (hold_r != 3'h0) begin
      hold_r <= hold_r - 3'h1;
    end else begin
      pin_r <= 8'h00;
    end
  end
  // Released lines fall back to their idle low level
  assign wake_pin = pin_r;
endmodule // sss_wake_dev

// ===== dv/testbench.sv
// Self-checking bench: bus master, sleep entry, wake, status and irq
// Assumes sss_top, the wake device model and the bound checker
`timescale 1ns/10ps
`include "sss_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %h exp %h", $time, g, e); end end
module testbench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, cpu_halt, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdat, desc;
  logic [3:0] strb;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] wake_pin, pwr_off, fire, map;
  sss_pkg::sss_typ_t typ;
  int seed, n_mismatch, n_checks, i, p;
  sss_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wake_pin(wake_pin), .pwr_off(pwr_off), .cpu_halt(cpu_halt), .irq(irq));
  sss_wake_dev dev_u (.aclk(aclk), .fire(fire), .wake_pin(wake_pin));
  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tmo();
    n_mismatch++;
    end_of_test();
  endtask
  // Write; response ready offered together with the request
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int k;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (k == 64) tmo();
    resp = bresp;
    @(posedge aclk);
  endtask
  // Read; data ready offered together with the request
  task automatic rd(input logic [11:0] a);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (k == 64) tmo();
    rdat = rdata;
    resp = rresp;
    @(posedge aclk);
  endtask
  // Bounded poll of a register field
  task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
    int k;
    for (k = 0; k < 40; k++) begin
      rd(a);
      if ((rdat & m) === v) break;
    end
    if (k == 40) tmo();
  endtask
  function automatic logic [31:0] ctl(input sss_pkg::sss_typ_t t, input logic en);
    return {18'h0, en, t, 10'h0};
  endfunction
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, fire} = '0;
    strb = 4'hf;
    seed = 86;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(12'h018);
    `CHK(rdat, 32'h1)
    rd(12'h000);
    `CHK(rdat, 32'h0)
    `CHK({irq, cpu_halt, pwr_off}, 10'h0)
    rd(12'h0fc);
    `CHK({resp, rdat}, {2'b10, 32'h0})
    $display("test reset done");
    for (i = 0; i < 2; i++) begin
      typ = 3'($random(seed));
      if (typ == 3'h0) typ = 3'h1;
      desc = {16'h0, 5'h0, typ, 5'h0, typ};
      map = 8'($random(seed));
      map[0] = 1'b1;
      p = $random(seed) & 7;
      wr(12'h014, {24'h0, map});
      wr(12'h010, 32'h1 << p);
      wr(12'h020, (i == 0) ? 32'h1 : 32'h0);
      rd(12'h014);
      `CHK(rdat[7:0], map)
      wr(12'h008, 32'h8000);
      wr(12'h00c, 32'h8000);
      wr(12'h000, ctl(desc[2:0], 1'b0));
      // Enable on a lane the control block ignores, then B alone
      strb <= 4'h1;
      wr(12'h000, ctl(desc[2:0], 1'b1));
      strb <= 4'hf;
      wr(12'h004, ctl(desc[10:8], 1'b1));
      repeat (`SSS_SETTLE_CYC + 10) @(posedge aclk);
      `CHK(cpu_halt, 1'b0)
      // Light sleep: straight to the enable, no cache flush step
      wr(12'h000, ctl(desc[2:0], 1'b1));
      wr(12'h004, ctl(desc[10:8], 1'b1));
      poll(12'h018, 32'hf, 32'h4);
      `CHK({cpu_halt, pwr_off}, {1'b1, map})
      wr(12'h000, ctl(typ ^ 3'h1, 1'b0));
      rd(12'h000);
      `CHK(rdat[12:10], typ)
      if (i == 1) begin
        fire <= 8'h1 << ((p + 1) % 8);
        @(posedge aclk);
        fire <= 8'h00;
        repeat (10) @(posedge aclk);
        rd(12'h018);
        `CHK(rdat, 32'h4)
      end
      fire <= 8'h1 << p;
      @(posedge aclk);
      fire <= 8'h00;
      poll(12'h008, 32'h8000, 32'h8000);
      rd(12'h00c);
      `CHK(rdat[15], 1'b1)
      rd(12'h018);
      `CHK({rdat, cpu_halt, pwr_off}, {32'h1, 9'h0})
      `CHK(irq, (i == 0))
      wr(12'h008, 32'h0);
      rd(12'h008);
      `CHK(rdat[15], 1'b1)
      wr(12'h008, 32'h8000);
      rd(12'h008);
      `CHK(rdat[15], 1'b0)
      wr(12'h01c, 32'h3);
      `CHK(irq, 1'b0)
      $display("test sleep %0d done", i);
    end
    end_of_test();
  end
endmodule // testbench

// ===== hw/sss_core.sv
// Sleep sequencer core: enter sleep on command, leave on wake event
// Assumes wake inputs already synchronised and enables applied upstream
`timescale 1ns/10ps
`include "sss_map.svh"
module sss_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wake_evt,
  input wire logic [7:0] pwr_map,
  sss_ctl_if.core ctl
);
  sss_pkg::sss_state_t st_r, st_nxt;
  sss_pkg::sss_typ_t typ_r, typ_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic a_seen_r, a_seen_nxt;
  logic [7:0] off_r, off_nxt;

  // Next state: sleep only on software command, wake without one
  always_comb begin
    st_nxt = st_r;
    typ_nxt = typ_r;
    cnt_nxt = cnt_r;
    a_seen_nxt = a_seen_r;
    off_nxt = off_r;
    case (st_r)
      sss_pkg::SSS_WORK: begin
        off_nxt = 8'h00;
        if (ctl.cmd_a) begin
          a_seen_nxt = 1'b1;
          typ_nxt = ctl.typ;
        end
        // Both blocks must carry the command before sequencing starts
        if (ctl.cmd_b && (a_seen_r || ctl.cmd_a)) begin
          st_nxt = sss_pkg::SSS_ENTER;
          cnt_nxt = 8'(`SSS_SETTLE_CYC);
          a_seen_nxt = 1'b0;
        end
      end
      sss_pkg::SSS_ENTER: begin
        off_nxt = pwr_map;
        if (cnt_r == 8'h00) begin
          st_nxt = sss_pkg::SSS_SLEEP;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      sss_pkg::SSS_SLEEP: begin
        if (wake_evt) begin
          st_nxt = sss_pkg::SSS_WAKE;
          off_nxt = 8'h00;
        end
      end
      sss_pkg::SSS_WAKE: begin
        st_nxt = sss_pkg::SSS_WORK;
      end
      default: begin
        st_nxt = sss_pkg::SSS_WORK;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= sss_pkg::SSS_WORK;
      typ_r <= `SSS_TYP_RST;
      cnt_r <= 8'h00;
      a_seen_r <= 1'b0;
      off_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      typ_r <= typ_nxt;
      cnt_r <= cnt_nxt;
      a_seen_r <= a_seen_nxt;
      off_r <= off_nxt;
    end
  end

  // Halt keeps context; DRAM untouched, no reset asserted
  assign ctl.cpu_halt = (st_r == sss_pkg::SSS_SLEEP) || (st_r == sss_pkg::SSS_ENTER);
  assign ctl.asleep = (st_r == sss_pkg::SSS_SLEEP);
  assign ctl.wake = (st_r == sss_pkg::SSS_WAKE);
  assign ctl.pwr_off = off_r;
  assign ctl.state = st_r;
endmodule // sss_core

// ===== hw/sss_top.sv
// AXI4-Lite register slave and wiring of the sleep sequencer
// Assumes wake pins asynchronous; power and halt outputs go to platform logic
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "sss_map.svh"
// Notes on behaviour
// - Writing one to the wake status bit clears it; writing zero leaves it.
// - Sleep begins only on a software write carrying sleep type and enable.
// - A wake event returns the system to working with no software command.
// - In light sleep processors halt with context kept and DRAM retained.
// - In light sleep power resources referenced at working level are switched off.
// - A sleeping device stays in a state only while its resources are on, else off.
// - An enabled wake device raises the event; the processor resumes where it stopped.
module sss_top (
  aclk,
  aresetn,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  wake_pin,
  pwr_off,
  cpu_halt,
  irq
);
  input wire logic aclk;
  input wire logic aresetn;
  input wire logic [11:0] s_axi_awaddr;
  input wire logic s_axi_awvalid;
  output logic s_axi_awready;
  input wire logic [31:0] s_axi_wdata;
  input wire logic [3:0] s_axi_wstrb;
  input wire logic s_axi_wvalid;
  output logic s_axi_wready;
  output logic [1:0] s_axi_bresp;
  output logic s_axi_bvalid;
  input wire logic s_axi_bready;
  input wire logic [11:0] s_axi_araddr;
  input wire logic s_axi_arvalid;
  output logic s_axi_arready;
  output logic [31:0] s_axi_rdata;
  output logic [1:0] s_axi_rresp;
  output logic s_axi_rvalid;
  input wire logic s_axi_rready;
  input wire logic [7:0] wake_pin;
  output logic [7:0] pwr_off;
  output logic cpu_halt;
  output logic irq;

  sss_ctl_if ctl ();

  // Register decode used by both the read and the write paths
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `SSS_IRQ_MASK_OFF);
  endfunction

  logic [7:0] sync1_r, sync2_r, wpin_prev_r;
  logic [1:0] wak_r, wak_nxt;
  logic [7:0] wake_en_r, wake_en_nxt;
  logic [7:0] pwr_map_r, pwr_map_nxt;
  logic [1:0] irq_sts_r, irq_sts_nxt;
  logic [1:0] irq_mask_r, irq_mask_nxt;
  logic [2:0] typ_a_r, typ_a_nxt;
  logic [2:0] typ_b_r, typ_b_nxt;
  logic cmd_a_r, cmd_a_nxt, cmd_b_r, cmd_b_nxt;
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [11:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
  logic [1:0] bresp_nxt, rresp_nxt;
  logic [31:0] rdata_nxt;
  logic [7:0] pwr_off_nxt;
  logic halt_nxt, irq_nxt;
  logic wake_evt;
  logic do_wr;
  logic [11:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;

  // Two-flop synchroniser on the asynchronous wake pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
      wpin_prev_r <= 8'h00;
    end else begin
      sync1_r <= wake_pin;
      sync2_r <= sync1_r;
      wpin_prev_r <= sync2_r;
    end
  end

  // Rising edge of an enabled wake source, only meaningful while asleep
  assign wake_evt = ctl.asleep && |(sync2_r & ~wpin_prev_r & wake_en_r);

  assign ctl.cmd_a = cmd_a_r;
  assign ctl.cmd_b = cmd_b_r;
  assign ctl.typ = typ_a_r;

  sss_core u_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .wake_evt(wake_evt),
    .pwr_map(pwr_map_r),
    .ctl(ctl)
  );

  // Write channel capture and register update
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    awready_nxt = 1'b0;
    wready_nxt = 1'b0;
    bvalid_nxt = s_axi_bvalid && !s_axi_bready;
    bresp_nxt = s_axi_bresp;
    wak_nxt = wak_r;
    wake_en_nxt = wake_en_r;
    pwr_map_nxt = pwr_map_r;
    irq_mask_nxt = irq_mask_r;
    irq_sts_nxt = irq_sts_r;
    typ_a_nxt = typ_a_r;
    typ_b_nxt = typ_b_r;
    cmd_a_nxt = 1'b0;
    cmd_b_nxt = 1'b0;
    wa = awaddr_r;
    wd = wdata_r;
    ws = wstrb_r;
    // Ready pulses one cycle, then the item is held until the response
    if (s_axi_awvalid && !aw_hold_r && !s_axi_awready && !s_axi_bvalid) begin
      awready_nxt = 1'b1;
    end
    if (s_axi_wvalid && !w_hold_r && !s_axi_wready && !s_axi_bvalid) begin
      wready_nxt = 1'b1;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
      wa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
      wd = s_axi_wdata;
      ws = s_axi_wstrb;
    end
    do_wr = aw_hold_nxt && w_hold_nxt;
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = mapped(wa) ? 2'b00 : 2'b10;
      case (wa)
        `SSS_CNT_A_OFF: begin
          if (ws[1]) begin
            typ_a_nxt = ctl.cpu_halt ? typ_a_r : wd[`SSS_TYP_MSB:`SSS_TYP_LSB];
            cmd_a_nxt = wd[`SSS_EN_BIT];
          end
        end
        `SSS_CNT_B_OFF: begin
          if (ws[1]) begin
            typ_b_nxt = ctl.cpu_halt ? typ_b_r : wd[`SSS_TYP_MSB:`SSS_TYP_LSB];
            cmd_b_nxt = wd[`SSS_EN_BIT];
          end
        end
        `SSS_STS_A_OFF: begin
          if (ws[1] && wd[`SSS_WAK_BIT]) wak_nxt[0] = 1'b0;
        end
        `SSS_STS_B_OFF: begin
          if (ws[1] && wd[`SSS_WAK_BIT]) wak_nxt[1] = 1'b0;
        end
        `SSS_WAKE_EN_OFF: begin
          if (ws[0]) wake_en_nxt = wd[7:0];
        end
        `SSS_PWR_MAP_OFF: begin
          if (ws[0]) pwr_map_nxt = wd[7:0];
        end
        `SSS_IRQ_STS_OFF: begin
          if (ws[0]) irq_sts_nxt = irq_sts_r & ~wd[1:0];
        end
        `SSS_IRQ_MASK_OFF: begin
          if (ws[0]) irq_mask_nxt = wd[1:0];
        end
        default: begin
          // Read-only or unmapped: nothing changes
          bresp_nxt = mapped(wa) ? 2'b00 : 2'b10;
        end
      endcase
    end
    // Hardware sets win over software clears
    if (ctl.wake) begin
      wak_nxt = 2'b11;
      irq_sts_nxt[0] = 1'b1;
    end
    // Sleep reached; set again each sleeping cycle, so it beats a clear
    if (ctl.asleep) irq_sts_nxt[1] = 1'b1;
  end

  // Read channel: one outstanding read, answered the cycle after arready
  always_comb begin
    arready_nxt = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    rvalid_nxt = s_axi_rvalid && !s_axi_rready;
    rdata_nxt = s_axi_rdata;
    rresp_nxt = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      case (s_axi_araddr)
        `SSS_CNT_A_OFF: rdata_nxt = {19'h0, typ_a_r, 10'h0};
        `SSS_CNT_B_OFF: rdata_nxt = {19'h0, typ_b_r, 10'h0};
        `SSS_STS_A_OFF: rdata_nxt = {16'h0, wak_r[0], 15'h0};
        `SSS_STS_B_OFF: rdata_nxt = {16'h0, wak_r[1], 15'h0};
        `SSS_WAKE_EN_OFF: rdata_nxt = {24'h0, wake_en_r};
        `SSS_PWR_MAP_OFF: rdata_nxt = {24'h0, pwr_map_r};
        `SSS_STATE_OFF: rdata_nxt = {28'h0, ctl.state};
        `SSS_IRQ_STS_OFF: rdata_nxt = {30'h0, irq_sts_r};
        `SSS_IRQ_MASK_OFF: rdata_nxt = {30'h0, irq_mask_r};
        default: rdata_nxt = 32'h0;
      endcase
    end
    pwr_off_nxt = ctl.pwr_off;
    halt_nxt = ctl.cpu_halt;
    irq_nxt = |(irq_sts_nxt & irq_mask_nxt);
  end

  // Registers only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
      wak_r <= 2'b00;
      wake_en_r <= `SSS_WAKE_EN_RST;
      pwr_map_r <= `SSS_PWR_MAP_RST;
      irq_sts_r <= 2'b00;
      irq_mask_r <= `SSS_IRQ_MASK_RST;
      typ_a_r <= `SSS_TYP_RST;
      typ_b_r <= `SSS_TYP_RST;
      cmd_a_r <= 1'b0;
      cmd_b_r <= 1'b0;
      pwr_off <= 8'h00;
      cpu_halt <= 1'b0;
      irq <= 1'b0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      s_axi_awready <= awready_nxt;
      s_axi_wready <= wready_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_bresp <= bresp_nxt;
      s_axi_arready <= arready_nxt;
      s_axi_rvalid <= rvalid_nxt;
      s_axi_rdata <= rdata_nxt;
      s_axi_rresp <= rresp_nxt;
      wak_r <= wak_nxt;
      wake_en_r <= wake_en_nxt;
      pwr_map_r <= pwr_map_nxt;
      irq_sts_r <= irq_sts_nxt;
      irq_mask_r <= irq_mask_nxt;
      typ_a_r <= typ_a_nxt;
      typ_b_r <= typ_b_nxt;
      cmd_a_r <= cmd_a_nxt;
      cmd_b_r <= cmd_b_nxt;
      pwr_off <= pwr_off_nxt;
      cpu_halt <= halt_nxt;
      irq <= irq_nxt;
    end
  end
endmodule // sss_top

// ===== shared/sss_ctl_if.sv
// Control bundle between the register slave and the sequencer core
// Assumes one clock shared by both ends
`timescale 1ns/10ps
interface sss_ctl_if;
  logic cmd_a;
  logic cmd_b;
  logic [2:0] typ;
  logic wake;
  logic asleep;
  logic [7:0] pwr_off;
  logic cpu_halt;
  logic [3:0] state;
  modport core (input cmd_a, input cmd_b, input typ, output wake, output asleep,
    output pwr_off, output cpu_halt, output state);
  modport regs (output cmd_a, output cmd_b, output typ, input wake, input asleep,
    input pwr_off, input cpu_halt, input state);
endinterface

// ===== shared/sss_map.svh
// Register map, field positions, reset values and timing counts
// Assumes inclusion by the sleep sequencer top, its core and the testbench
`ifndef SSS_MAP_SVH
`define SSS_MAP_SVH
`define SSS_CNT_A_OFF 12'h000
`define SSS_CNT_B_OFF 12'h004
`define SSS_STS_A_OFF 12'h008
`define SSS_STS_B_OFF 12'h00c
`define SSS_WAKE_EN_OFF 12'h010
`define SSS_PWR_MAP_OFF 12'h014
`define SSS_STATE_OFF 12'h018
`define SSS_IRQ_STS_OFF 12'h01c
`define SSS_IRQ_MASK_OFF 12'h020
`define SSS_TYP_LSB 10
`define SSS_TYP_MSB 12
`define SSS_EN_BIT 13
`define SSS_WAK_BIT 15
`define SSS_TYP_RST 3'h0
`define SSS_WAKE_EN_RST 8'h00
`define SSS_PWR_MAP_RST 8'h00
`define SSS_IRQ_MASK_RST 2'h0
`define SSS_SETTLE_NS 100
`define SSS_SETTLE_CYC ((`SSS_SETTLE_NS + 4) / 5)
`endif

// ===== shared/sss_pkg.sv
// Types shared by the sleep sequencer modules
// Assumes no other package
package sss_pkg;
  typedef enum logic [3:0] {
    SSS_WORK = 4'h1,
    SSS_ENTER = 4'h2,
    SSS_SLEEP = 4'h4,
    SSS_WAKE = 4'h8
  } sss_state_t;
  typedef logic [2:0] sss_typ_t;
endpackage
